//--- logic/afc_core.sv
// framing control, register file and converter capture of the audio block
//
// Overview of operation
// - frame bytes are frame length times 90
// - framed output opens with twelve header bytes
// - header part six bytes, packed ninety-six
// - interrupt pulse length from bits seven..one
// - input strobe edge chosen by polarity bit
// - output strobe inverted when polarity bit set
// - sample width is field value plus one
// - skip position bits after each sample word
// - discard frames while skip count nonzero
// - software and hardware reset load values
// - converter enable selects sample source
// - two-bit code selects compression algorithm
`timescale 1ns/1ps
module afc_core
  import afc_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clock_i, // system clock
  input wire logic rst_i, // hardware reset, sync high
  input wire logic sw_rst_i, // software reset pulse
  input wire logic reg_wr_i, // register write strobe
  input wire logic [7:0] reg_addr_i, // register offset
  input wire logic [7:0] reg_wdata_i, // write data
  output logic [7:0] reg_rdata_o, // read data
  input wire logic frame_start_i, // new compressed frame
  input wire logic irq_event_i, // engine event
  output logic irq_o, // interrupt pulse
  output logic frame_drop_o, // current frame discarded
  output logic [15:0] frame_bytes_o, // bytes per frame
  output logic [15:0] header_bytes_o, // header bytes
  output logic [15:0] header_part_o, // header part bytes
  input wire logic [1:0] algorithm_select_i, // hi and lo code bits
  input wire logic converter_source_select_i, // converter enable
  input wire logic port_strobe_i, // port strobe pin
  input wire logic port_data_i, // port data pin
  output logic port_bit_o, // captured input bit
  input wire logic port_strobe_int_i, // internal output strobe
  output logic port_strobe_o, // driven strobe
  input wire logic stream_valid_i, // bitstream sample valid
  input wire logic [31:0] stream_sample_i, // bitstream sample
  input wire logic bit_clock_i, // converter bit clock
  input wire logic left_right_clock_i, // converter slot clock
  input wire logic adc_data_i, // converter serial data
  output logic sample_valid_o, // sample to compress
  output logic [31:0] sample_o, // sample word
  input wire logic sample_ready_i // engine takes sample
);
  // ----------------------------------------
  // system domain state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] frame_len;
    logic [7:0] irq_cfg;
    logic [7:0] pol;
    logic [7:0] wlen;
    logic [7:0] wpos;
    logic [7:0] skip;
    logic [7:0] irq_cnt;
    logic drop;
    logic [2:0] strobe_sync;
    logic [1:0] data_sync;
    logic port_bit;
    logic [2:0] tog_sync;
    logic [7:0] rdata;
  } afc_sys_s;
  afc_sys_s st_ff;
  afc_sys_s nxt_st;
  // ----------------------------------------
  // link domain state
  // ----------------------------------------
  typedef struct packed {
    logic [4:0] wlen;
    logic [4:0] wpos;
    logic [5:0] bitcnt;
    logic [31:0] shift;
    logic lr_prev;
    logic [31:0] word;
    logic tog;
  } afc_link_s;
  afc_link_s lk_ff;
  afc_link_s nxt_lk;
  logic [4:0] cfg_wlen_lk;
  logic [4:0] cfg_wpos_lk;
  logic [9:0] cfg_sync1_ff;
  logic [9:0] cfg_sync2_ff;
  logic [1:0] lk_rst_ff;
  logic [31:0] word_sys;
  logic tog_edge;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [31:0] fifo_in_data;
  logic strobe_rise;
  logic strobe_fall;

  // ----------------------------------------
  // register file, frame skip and interrupt
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.strobe_sync = {st_ff.strobe_sync[1:0], port_strobe_i};
    nxt_st.data_sync = {st_ff.data_sync[0], port_data_i};
    nxt_st.tog_sync = {st_ff.tog_sync[1:0], lk_ff.tog};
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_FRAME_LEN: nxt_st.frame_len = reg_wdata_i;
        OFS_IRQ_CFG: nxt_st.irq_cfg = reg_wdata_i;
        OFS_STROBE_POL: nxt_st.pol = reg_wdata_i;
        OFS_WORD_LEN: nxt_st.wlen = reg_wdata_i;
        OFS_WORD_POS: nxt_st.wpos = reg_wdata_i;
        OFS_SKIP_CNT: nxt_st.skip = reg_wdata_i;
        default: nxt_st.rdata = st_ff.rdata;
      endcase
    end
    if (frame_start_i) begin
      nxt_st.drop = (st_ff.skip != 8'h00);
      if (st_ff.skip != 8'h00) begin
        nxt_st.skip = st_ff.skip - 8'h01;
      end
    end
    if (irq_event_i) begin
      nxt_st.irq_cnt = {1'b0, st_ff.irq_cfg[IRQ_LEN_MSB:IRQ_LEN_LSB]};
    end else if (st_ff.irq_cnt != 8'h00) begin
      nxt_st.irq_cnt = st_ff.irq_cnt - 8'h01;
    end
    if ((st_ff.pol[IN_POL_BIT] && strobe_rise) ||
        (!st_ff.pol[IN_POL_BIT] && strobe_fall)) begin
      nxt_st.port_bit = st_ff.data_sync[1];
    end
    case (reg_addr_i)
      OFS_FRAME_LEN: nxt_st.rdata = st_ff.frame_len;
      OFS_IRQ_CFG: nxt_st.rdata = st_ff.irq_cfg;
      OFS_STROBE_POL: nxt_st.rdata = {6'h00, st_ff.pol[1:0]};
      OFS_WORD_LEN: nxt_st.rdata = {3'h0, st_ff.wlen[FIELD5_MSB:0]};
      OFS_WORD_POS: nxt_st.rdata = {3'h0, st_ff.wpos[FIELD5_MSB:0]};
      OFS_SKIP_CNT: nxt_st.rdata = st_ff.skip;
      default: nxt_st.rdata = 8'h00;
    endcase
    if (sw_rst_i) begin
      nxt_st.frame_len = SW_FRAME_LEN;
      nxt_st.irq_cfg = SW_IRQ_CFG;
      nxt_st.pol = RST_STROBE_POL;
      nxt_st.wlen = RST_WORD_LEN;
      nxt_st.wpos = RST_WORD_POS;
      nxt_st.skip = RST_SKIP_CNT;
    end
  end
  assign strobe_rise = st_ff.strobe_sync[1] && !st_ff.strobe_sync[2];
  assign strobe_fall = !st_ff.strobe_sync[1] && st_ff.strobe_sync[2];
  assign tog_edge = st_ff.tog_sync[1] ^ st_ff.tog_sync[2];

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.frame_len <= HW_FRAME_LEN;
      st_ff.irq_cfg <= HW_IRQ_CFG;
      st_ff.wlen <= RST_WORD_LEN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_o = st_ff.rdata;
  assign irq_o = (st_ff.irq_cnt != 8'h00);
  assign frame_drop_o = st_ff.drop;
  assign port_bit_o = st_ff.port_bit;
  assign port_strobe_o = port_strobe_int_i ^ st_ff.pol[OUT_POL_BIT];
  assign frame_bytes_o = 16'(st_ff.frame_len * FRAME_UNIT);
  assign header_bytes_o = HEADER_BYTES;
  assign header_part_o = (afc_alg_e'(algorithm_select_i) == ALG_FIRST) ?
                         HDR_PART_FIRST : HDR_PART_PACKED;

  // ----------------------------------------
  // link domain: converter capture
  // ----------------------------------------
  // settings are quasi-static: the link takes them only at a slot edge,
  // so a write must lead the slot by two bit clocks or more
  always_ff @(posedge bit_clock_i) begin
    lk_rst_ff <= {lk_rst_ff[0], rst_i};
    cfg_sync1_ff <= {st_ff.wpos[4:0], st_ff.wlen[4:0]};
    cfg_sync2_ff <= cfg_sync1_ff;
  end
  assign cfg_wlen_lk = cfg_sync2_ff[4:0];
  assign cfg_wpos_lk = cfg_sync2_ff[9:5];

  always_comb begin
    nxt_lk = lk_ff;
    nxt_lk.lr_prev = left_right_clock_i;
    if (left_right_clock_i != lk_ff.lr_prev) begin
      nxt_lk.wlen = cfg_wlen_lk;
      nxt_lk.wpos = cfg_wpos_lk;
      nxt_lk.bitcnt = 6'h01;
      nxt_lk.shift = {31'h0, adc_data_i};
      // a one-bit slot is complete at its own boundary edge
      if (cfg_wlen_lk == 5'h00 && cfg_wpos_lk == 5'h00) begin
        nxt_lk.word = nxt_lk.shift;
        nxt_lk.tog = !lk_ff.tog;
      end
    end else if (lk_ff.bitcnt != 6'h3F) begin
      // bitcnt holds the bits already taken in this slot
      nxt_lk.bitcnt = lk_ff.bitcnt + 6'h01;
      if (lk_ff.bitcnt <= {1'b0, lk_ff.wlen}) begin
        nxt_lk.shift = {lk_ff.shift[30:0], adc_data_i};
      end
      // last bit of word plus skipped bits closes the slot: hand the word over
      if (lk_ff.bitcnt == {1'b0, lk_ff.wlen} + {1'b0, lk_ff.wpos}) begin
        nxt_lk.word = nxt_lk.shift;
        nxt_lk.tog = !lk_ff.tog;
      end
    end
  end
  always_ff @(posedge bit_clock_i) begin
    if (lk_rst_ff[1]) begin
      lk_ff <= '0;
      // counter parked and slot clock tracked: no slot opens in reset
      lk_ff.bitcnt <= 6'h3F;
      lk_ff.lr_prev <= left_right_clock_i;
    end else begin
      lk_ff <= nxt_lk;
    end
  end

  // word changes with the toggle, so it is stable for at least two system clocks before the toggle is seen
  assign word_sys = lk_ff.word;

  // ----------------------------------------
  // sample source and buffer
  // ----------------------------------------
  assign fifo_in_valid = converter_source_select_i ? tog_edge :
                         stream_valid_i;
  assign fifo_in_data = converter_source_select_i ? word_sys :
                        stream_sample_i;

  afc_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_in_valid),
    .in_data_i(fifo_in_data),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(sample_valid_o),
    .out_data_o(sample_o),
    .out_ready_i(sample_ready_i)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_irq_len;
    @(posedge clock_i) disable iff (rst_i || sw_rst_i)
    (irq_event_i && st_ff.irq_cfg[7:1] == 7'd3) |=> irq_o [*3];
  endproperty
  a_irq_len: assert property (p_irq_len)
    else $error("interrupt pulse length wrong");
  property p_skip;
    @(posedge clock_i) disable iff (rst_i)
    (frame_start_i && st_ff.skip != 8'h00 && !reg_wr_i && !sw_rst_i)
      |=> (frame_drop_o && st_ff.skip == $past(st_ff.skip) - 8'h01);
  endproperty
  a_skip: assert property (p_skip)
    else $error("frame skip not applied");
  property p_swrst;
    @(posedge clock_i) disable iff (rst_i)
    sw_rst_i |=> (st_ff.frame_len == 8'h13 && st_ff.irq_cfg == 8'h0B);
  endproperty
  a_swrst: assert property (p_swrst)
    else $error("software reset values wrong");
  property p_frame;
    @(posedge clock_i) disable iff (rst_i)
    frame_bytes_o == 16'(st_ff.frame_len) * 16'd90;
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame size wrong");
  property p_ostrobe;
    @(posedge clock_i) disable iff (rst_i)
    st_ff.pol[1] |-> (port_strobe_o != port_strobe_int_i);
  endproperty
  a_ostrobe: assert property (p_ostrobe)
    else $error("output strobe polarity wrong");
  property p_hdr;
    @(posedge clock_i) disable iff (rst_i)
    (algorithm_select_i != 2'b00) |-> header_part_o == 16'd96;
  endproperty
  a_hdr: assert property (p_hdr)
    else $error("header part size wrong");
  property p_src;
    @(posedge clock_i) disable iff (rst_i)
    (!converter_source_select_i && stream_valid_i && fifo_in_ready)
      |=> sample_valid_o;
  endproperty
  a_src: assert property (p_src)
    else $error("stream sample not buffered");
  property p_conv;
    @(posedge clock_i) disable iff (rst_i)
    (converter_source_select_i && tog_edge && fifo_in_ready)
      |=> sample_valid_o;
  endproperty
  a_conv: assert property (p_conv)
    else $error("converter word not buffered");
  property p_hw;
    @(posedge clock_i) $past(rst_i) |-> (st_ff.frame_len == 8'h00 &&
      st_ff.wlen == 8'h0F);
  endproperty
  a_hw: assert property (p_hw)
    else $error("hardware reset values wrong");
endmodule : afc_core

//--- logic/afc_pkg.sv
// package: register map, field layout, reset values and timing constants
package afc_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_FRAME_LEN = 8'hBD;
  localparam logic [7:0] OFS_IRQ_CFG = 8'hBE;
  localparam logic [7:0] OFS_STROBE_POL = 8'hBF;
  localparam logic [7:0] OFS_WORD_LEN = 8'hC0;
  localparam logic [7:0] OFS_WORD_POS = 8'hC1;
  localparam logic [7:0] OFS_SKIP_CNT = 8'hC2;
  // ----------------------------------------
  // reset values: hardware and software
  // ----------------------------------------
  localparam logic [7:0] HW_FRAME_LEN = 8'h00;
  localparam logic [7:0] SW_FRAME_LEN = 8'h13;
  localparam logic [7:0] HW_IRQ_CFG = 8'h00;
  localparam logic [7:0] SW_IRQ_CFG = 8'h0B;
  localparam logic [7:0] RST_STROBE_POL = 8'h00;
  localparam logic [7:0] RST_WORD_LEN = 8'h0F;
  localparam logic [7:0] RST_WORD_POS = 8'h00;
  localparam logic [7:0] RST_SKIP_CNT = 8'h00;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int IRQ_LEN_LSB = 1;
  localparam int IRQ_LEN_MSB = 7;
  localparam int IN_POL_BIT = 0;
  localparam int OUT_POL_BIT = 1;
  localparam int FIELD5_MSB = 4;
  // ----------------------------------------
  // framing figures
  // ----------------------------------------
  localparam logic [15:0] FRAME_UNIT = 16'h005A;
  localparam logic [15:0] HEADER_BYTES = 16'h000C;
  localparam logic [15:0] HDR_PART_FIRST = 16'h0006;
  localparam logic [15:0] HDR_PART_PACKED = 16'h0060;
  // ----------------------------------------
  // algorithm codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    ALG_FIRST = 2'b00,
    ALG_PACK24 = 2'b01,
    ALG_PACK32 = 2'b10,
    ALG_PACK40 = 2'b11
  } afc_alg_e;
  // ----------------------------------------
  // far-side timing, for reference
  // ----------------------------------------
  localparam int SRC_LOW_NS = 50;
  localparam int RESET_LOW_NS = 100;
  localparam int CLK_NS = 50;
  localparam int SRC_LOW_CYC = (SRC_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_NS - 1) / CLK_NS;
endpackage : afc_pkg

//--- logic/afc_fifo.sv
// sample fifo in the system domain, between source select and engine
`timescale 1ns/1ps
module afc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clock_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire logic in_valid_i, // word offered
  input wire logic [WIDTH-1:0] in_data_i, // word
  output logic in_ready_o, // space free
  output logic out_valid_o, // word held
  output logic [WIDTH-1:0] out_data_o, // oldest word
  input wire logic out_ready_i // drain accepts
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } afc_fifo_s;
  afc_fifo_s st_ff;
  afc_fifo_s nxt_st;
  logic push;
  logic pop;
  assign in_ready_o = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_ff.cnt != '0);
  assign out_data_o = st_ff.mem[st_ff.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data_i;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : afc_fifo

//--- dv/afc_conv_model.sv
// serial audio converter model: bit clock, slot clock and data
`timescale 1ns/1ps
module afc_conv_model (
  output logic bit_clock_o, // link bit clock, 48 ns
  output logic left_right_clock_o, // slot clock
  output logic adc_data_o // serial data
);
  initial begin
    bit_clock_o = 1'b0;
    left_right_clock_o = 1'b0;
    adc_data_o = 1'b0;
  end
  // one slot: idle lead-in clocks, then word msb first, then filler
  task automatic send(input logic [31:0] w, input int nb, input int np);
    int i;
    // lead-in lets settings and reset cross before the slot opens
    repeat (3) begin
      #24 bit_clock_o = 1'b1;
      #24 bit_clock_o = 1'b0;
    end
    left_right_clock_o = ~left_right_clock_o;
    for (i = nb + np - 1; i >= 0; i--) begin
      adc_data_o = (i >= np) ? w[i-np] : ~adc_data_o;
      #24 bit_clock_o = 1'b1;
      #24 bit_clock_o = 1'b0;
    end
    adc_data_o = ~adc_data_o;
  endtask : send
endmodule : afc_conv_model

//--- dv/adpcm_frame_and_adc_capture_tb.sv
// self-checking bench of the framing control and converter capture
`timescale 1ns/1ps
module adpcm_frame_and_adc_capture_tb;
  import afc_pkg::*;
  logic clock_i, rst_i, sw_rst_i, reg_wr_i, frame_start_i, irq_event_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic irq_o, frame_drop_o, port_bit_o, port_strobe_o;
  logic [15:0] frame_bytes_o, header_bytes_o, header_part_o;
  logic [1:0] algorithm_select_i;
  logic converter_source_select_i, port_strobe_i, port_data_i;
  logic port_strobe_int_i, stream_valid_i, sample_valid_o, sample_ready_i;
  logic [31:0] stream_sample_i, sample_o, w, q[$];
  logic bclk, lrclk, adat;
  int bad_count, tests_run, n;
  logic [7:0] ofs [6] = '{OFS_FRAME_LEN, OFS_IRQ_CFG, OFS_STROBE_POL,
    OFS_WORD_LEN, OFS_WORD_POS, OFS_SKIP_CNT};
  logic [7:0] hwv [6] = '{8'h00, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h00};
  logic [7:0] swv [6] = '{8'h13, 8'h0B, 8'h00, 8'h0F, 8'h00, 8'h00};
  afc_conv_model afc_conv_model_i (.bit_clock_o(bclk),
    .left_right_clock_o(lrclk), .adc_data_o(adat));
  afc_core #(.FIFO_DEPTH(16)) afc_core_i (.clock_i(clock_i), .rst_i(rst_i),
    .sw_rst_i(sw_rst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .frame_start_i(frame_start_i), .irq_event_i(irq_event_i),
    .irq_o(irq_o), .frame_drop_o(frame_drop_o),
    .frame_bytes_o(frame_bytes_o), .header_bytes_o(header_bytes_o),
    .header_part_o(header_part_o), .algorithm_select_i(algorithm_select_i),
    .converter_source_select_i(converter_source_select_i),
    .port_strobe_i(port_strobe_i), .port_data_i(port_data_i),
    .port_bit_o(port_bit_o), .port_strobe_int_i(port_strobe_int_i),
    .port_strobe_o(port_strobe_o), .stream_valid_i(stream_valid_i),
    .stream_sample_i(stream_sample_i), .bit_clock_i(bclk),
    .left_right_clock_i(lrclk), .adc_data_i(adat),
    .sample_valid_o(sample_valid_o), .sample_o(sample_o),
    .sample_ready_i(sample_ready_i));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] exp_part(input logic [1:0] a);
    return (a == 2'b00) ? 32'h6 : 32'h60;
  endfunction : exp_part
  task automatic chk_val(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val
  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
  endtask : tick
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic chk_reg(input logic [7:0] a, e);
    @(posedge clock_i);
    reg_addr_i <= a;
    tick(2);
    #1 chk_val("register read", {24'h0, e}, {24'h0, reg_rdata_o});
  endtask : chk_reg
  task automatic pulse(input int sel);
    @(posedge clock_i);
    if (sel == 0) sw_rst_i <= 1'b1;
    else if (sel == 1) irq_event_i <= 1'b1;
    else frame_start_i <= 1'b1;
    @(posedge clock_i);
    {sw_rst_i, irq_event_i, frame_start_i} <= 3'b000;
  endtask : pulse
  task automatic drain(input int k);
    n = 0;
    repeat (k) begin
      @(negedge clock_i);
      if (sample_valid_o === 1'b1 && sample_ready_i === 1'b1) begin
        chk_val("sample", (q.size() > 0) ? q.pop_front() : 32'h0, sample_o);
        n++;
      end
    end
  endtask : drain
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  initial begin
    #3_000_000;
    bad_count++;
    summarize();
  end
  initial begin
    {rst_i, sw_rst_i, reg_wr_i, frame_start_i, irq_event_i} = 5'b10000;
    {reg_addr_i, reg_wdata_i, algorithm_select_i} = '0;
    {converter_source_select_i, port_strobe_i, port_data_i} = '0;
    {port_strobe_int_i, stream_valid_i, sample_ready_i} = '0;
    stream_sample_i = '0;
    void'($urandom(32'hE47D278E));
    afc_conv_model_i.send(32'h5, 4, 0);
    tick(12);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) chk_reg(ofs[i], hwv[i]);
    wr(8'hC3, 8'hA5);
    chk_reg(8'hC3, 8'h00);
    wr(OFS_STROBE_POL, 8'hFF);
    chk_reg(OFS_STROBE_POL, 8'h03);
    pulse(0);
    for (int i = 0; i < 6; i++) chk_reg(ofs[i], swv[i]);
    for (int a = 0; a < 4; a++) begin
      w = $urandom & 32'hFF;
      wr(OFS_FRAME_LEN, w[7:0]);
      algorithm_select_i <= a[1:0];
      tick(2);
      chk_val("frame bytes", w * 90, {16'h0, frame_bytes_o});
      chk_val("header", 32'hC, {16'h0, header_bytes_o});
      chk_val("part", exp_part(a[1:0]), {16'h0, header_part_o});
    end
    foreach (hwv[k]) begin
      w = (k == 0) ? 0 : (k == 1) ? 1 : (k == 2) ? 127 : (k == 3) ? 3 :
          $urandom % 128;
      wr(OFS_IRQ_CFG, {w[6:0], 1'b1});
      pulse(1);
      n = 0;
      repeat (140) begin
        @(negedge clock_i);
        if (irq_o === 1'b1) n++;
      end
      chk_val("irq length", w, n);
    end
    wr(OFS_SKIP_CNT, 8'h02);
    for (int f = 0; f < 3; f++) begin
      pulse(2);
      #1 chk_val("frame drop", (f < 2), frame_drop_o);
    end
    chk_reg(OFS_SKIP_CNT, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(OFS_STROBE_POL, {6'h0, p[1], 1'b0});
      port_strobe_int_i <= p[0];
      tick(1);
      #1 chk_val("strobe out", p[0] ^ p[1], port_strobe_o);
    end
    for (int p = 0; p < 4; p++) begin
      wr(OFS_STROBE_POL, {7'h0, p[1]});
      port_strobe_i <= ~p[1];
      port_data_i <= p[0];
      tick(6);
      port_strobe_i <= p[1];
      tick(6);
      port_data_i <= ~p[0];
      chk_val("port in", p[0], port_bit_o);
    end
    converter_source_select_i <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      w = (t == 0) ? 31 : $urandom % 32;
      n = (t == 1) ? 31 : $urandom % 4;
      wr(OFS_WORD_LEN, w[7:0]);
      wr(OFS_WORD_POS, n[7:0]);
      q.push_back($urandom & ((64'h1 << (w + 1)) - 1));
      afc_conv_model_i.send(q[0], w + 1, n);
      tick(8);
      sample_ready_i <= 1'b1;
      drain(1);
      chk_val("converter words", 1, n);
      @(posedge clock_i);
      sample_ready_i <= 1'b0;
    end
    converter_source_select_i <= 1'b0;
    q.delete();
    for (int i = 0; i < 20; i++) begin
      @(posedge clock_i);
      stream_valid_i <= 1'b1;
      stream_sample_i <= $urandom;
      #1 if (i < 16) q.push_back(stream_sample_i);
    end
    @(posedge clock_i);
    stream_valid_i <= 1'b0;
    tick(4);
    sample_ready_i <= 1'b1;
    drain(30);
    chk_val("fifo words", 16, n);
    summarize();
  end
endmodule : adpcm_frame_and_adc_capture_tb
